/* logic/gpd_port.sv */
// gpio port block: apb registers, pin control, debounce and edge flags
`timescale 1ns/1ns
module gpd_port #(
  parameter int CHECK_BASE = gpd_pkg::CHECK_BASE_CYCLES,
  parameter bit FIXED_SELECT_RO = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [gpd_pkg::NPORT*8-1:0] pin_in,
  output logic [gpd_pkg::NPORT*8-1:0] pin_out,
  output logic [gpd_pkg::NPORT*8-1:0] pin_oe_n,
  output logic [gpd_pkg::NPORT*8-1:0] pin_pullup_en,
  output logic [gpd_pkg::NPORT*8-1:0] pin_schmitt_en,
  // peripheral functions
  input wire logic [gpd_pkg::NPORT*8-1:0] periph_out,
  input wire logic [gpd_pkg::NPORT*8-1:0] periph_oe,
  input wire logic [gpd_pkg::NPORT*8-1:0] periph_ie,
  output logic [gpd_pkg::NPORT*8-1:0] periph_in,
  input wire logic debug_clock_src,
  // to port interrupt logic
  output logic [gpd_pkg::NFILT_PORT*8-1:0] filtered_value,
  output logic [gpd_pkg::NFILT_PORT*8-1:0] edge_flag
);
  localparam int NB = gpd_pkg::NPORT * 8;
  localparam int NF = gpd_pkg::NFILT_PORT * 8;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [gpd_pkg::NPORT-1:0][7:0] port_output_value;
  logic [gpd_pkg::NPORT-1:0][7:0] port_drive_enable;
  logic [gpd_pkg::NPORT-1:0][7:0] port_sense_enable;
  logic [gpd_pkg::NPORT-1:0][7:0] port_pullup_enable;
  logic [gpd_pkg::NPORT-1:0][7:0] port_input_level_select;
  logic [gpd_pkg::NPORT-1:0][7:0] port_function_select;
  logic [gpd_pkg::NFILT_PORT-1:0][7:0] port_debounce_config;
  logic [gpd_pkg::NFILT_PORT-1:0][7:0] port_edge_polarity;
  logic [gpd_pkg::NFILT_PORT-1:0][7:0] port_edge_flag;
  logic debug_clock_pin_select;

  logic [NB-1:0] pin_meta;
  logic [NB-1:0] pin_sync;
  logic [NF-1:0] filt_prev;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire [1:0] sel_port = paddr[gpd_pkg::PORT_SHIFT+1:gpd_pkg::PORT_SHIFT];
  wire [3:0] sel_reg = paddr[5:2];
  wire is_debug = (paddr == gpd_pkg::ADDR_DEBUG_SELECT);
  wire in_ports = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
  wire filt_port = (32'(sel_port) < gpd_pkg::NFILT_PORT);
  wire filt_reg = (sel_reg == gpd_pkg::REG_EDGE_POLARITY) ||
    (sel_reg == gpd_pkg::REG_EDGE_FLAG) ||
    (sel_reg == gpd_pkg::REG_DEBOUNCE_CONFIG);
  wire mapped = is_debug ||
    (in_ports && (sel_reg <= gpd_pkg::REG_LAST) && (filt_port || !filt_reg));
  wire setup = psel && !penable;
  wire wr_take = psel && penable && pready && pwrite && mapped;

  function automatic logic wr_hit(input logic [3:0] r, input int p);
    wr_hit = wr_take && in_ports && (sel_reg == r) && (32'(sel_port) == p);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset leaves every pin pulled up, so idle high
      pin_meta <= '1;
      pin_sync <= '1;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-bit pin control
  wire [NB-1:0] func_sel = port_function_select;
  wire [NB-1:0] is_debug_pin = NB'(1) << (gpd_pkg::DEBUG_PORT * 8 +
    gpd_pkg::DEBUG_BIT);
  // peripheral overrides the direction bits, not the pull-up
  wire [NB-1:0] eff_oe = (func_sel & periph_oe) |
    (~func_sel & port_drive_enable) | is_debug_pin;
  wire [NB-1:0] eff_ie = ((func_sel & periph_ie) |
    (~func_sel & port_sense_enable)) & ~is_debug_pin;
  wire debug_level = debug_clock_pin_select ?
    port_output_value[gpd_pkg::DEBUG_PORT][gpd_pkg::DEBUG_BIT] :
    debug_clock_src;
  wire [NB-1:0] gp_level = (func_sel & periph_out) |
    (~func_sel & port_output_value);
  wire [NB-1:0] next_pin_out = (gp_level & ~is_debug_pin) |
    ({NB{debug_level}} & is_debug_pin);
  // pin value reads the pad whenever input is on, even while driving
  wire [NB-1:0] next_pin_value = pin_sync & eff_ie;
  wire [NB-1:0] next_pullup = port_pullup_enable & ~eff_oe;
  logic [NB-1:0] next_schmitt;

  genvar gp;
  generate
    for (gp = 0; gp < gpd_pkg::NPORT; gp++) begin : g_level
      // fixed ports keep the schmitt level whatever the select bit holds
      if (gp < gpd_pkg::NFILT_PORT) begin : g_sel
        assign next_schmitt[gp*8 +: 8] = port_input_level_select[gp];
      end else begin : g_fix
        assign next_schmitt[gp*8 +: 8] = 8'hFF;
      end
    end
  endgenerate

  // registered pad controls; oe is low while the pin is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_pullup_en <= '1;
      pin_schmitt_en <= '1;
      periph_in <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= ~eff_oe;
      pin_pullup_en <= next_pullup;
      pin_schmitt_en <= next_schmitt & ~is_debug_pin;
      periph_in <= next_pin_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // debounce filters, one per nibble of the first two ports
  logic [NF-1:0] filt_out;
  genvar gf;
  generate
    for (gf = 0; gf < gpd_pkg::NFILT_PORT; gf++) begin : g_filt
      gpd_filter #(.BASE(CHECK_BASE)) u_low (
        .pclk(pclk),
        .presetn(presetn),
        .check_code(port_debounce_config[gf][gpd_pkg::LOW_CHECK_LSB +:
          gpd_pkg::CHECK_W]),
        .din(next_pin_value[gf*8 +: 4]),
        .dout(filt_out[gf*8 +: 4])
      );
      gpd_filter #(.BASE(CHECK_BASE)) u_high (
        .pclk(pclk),
        .presetn(presetn),
        .check_code(port_debounce_config[gf][gpd_pkg::HIGH_CHECK_LSB +:
          gpd_pkg::CHECK_W]),
        .din(next_pin_value[gf*8+4 +: 4]),
        .dout(filt_out[gf*8+4 +: 4])
      );
    end
  endgenerate

  wire [NF-1:0] polarity = port_edge_polarity;
  wire [NF-1:0] rise = filt_out & ~filt_prev;
  wire [NF-1:0] fall = ~filt_out & filt_prev;
  wire [NF-1:0] edge_hit = (rise & ~polarity) | (fall & polarity);

  ////////////////////////////////////////////////////////////////////////
  // register writes
  logic [NF-1:0] flag_clear;
  genvar gw;
  generate
    for (gw = 0; gw < gpd_pkg::NPORT; gw++) begin : g_wr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_output_value[gw] <= gpd_pkg::RST_OUTPUT_VALUE;
          port_drive_enable[gw] <= gpd_pkg::RST_DRIVE_ENABLE;
          port_sense_enable[gw] <= gpd_pkg::RST_SENSE_ENABLE;
          port_pullup_enable[gw] <= gpd_pkg::RST_PULLUP_ENABLE;
          port_input_level_select[gw] <= gpd_pkg::RST_LEVEL_SELECT;
          port_function_select[gw] <= gpd_pkg::RST_FUNCTION_SELECT;
        end else begin
          if (wr_hit(gpd_pkg::REG_OUTPUT_VALUE, gw))
            port_output_value[gw] <= pwdata[7:0];
          if (wr_hit(gpd_pkg::REG_DRIVE_ENABLE, gw))
            port_drive_enable[gw] <= pwdata[7:0];
          if (wr_hit(gpd_pkg::REG_SENSE_ENABLE, gw))
            port_sense_enable[gw] <= pwdata[7:0];
          if (wr_hit(gpd_pkg::REG_PULLUP_ENABLE, gw))
            port_pullup_enable[gw] <= pwdata[7:0];
          if (wr_hit(gpd_pkg::REG_LEVEL_SELECT, gw) &&
              (gw < gpd_pkg::NFILT_PORT || !FIXED_SELECT_RO))
            port_input_level_select[gw] <= pwdata[7:0];
          if (wr_hit(gpd_pkg::REG_FUNCTION_SELECT, gw))
            port_function_select[gw] <= pwdata[7:0];
        end
      end
    end
    for (gw = 0; gw < gpd_pkg::NFILT_PORT; gw++) begin : g_wrf
      // spelt out: a continuous assign misses globals read in a function
      assign flag_clear[gw*8 +: 8] = (wr_take && in_ports &&
        (sel_reg == gpd_pkg::REG_EDGE_FLAG) && (32'(sel_port) == gw)) ?
        pwdata[7:0] : 8'h00;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_debounce_config[gw] <= gpd_pkg::RST_DEBOUNCE_CONFIG;
          port_edge_polarity[gw] <= gpd_pkg::RST_EDGE_POLARITY;
          port_edge_flag[gw] <= 8'h00;
        end else begin
          if (wr_hit(gpd_pkg::REG_DEBOUNCE_CONFIG, gw))
            port_debounce_config[gw] <= pwdata[7:0] & 8'h77;
          if (wr_hit(gpd_pkg::REG_EDGE_POLARITY, gw))
            port_edge_polarity[gw] <= pwdata[7:0];
          // an edge in the clearing cycle survives the clear
          port_edge_flag[gw] <= (port_edge_flag[gw] &
            ~flag_clear[gw*8 +: 8]) | edge_hit[gw*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_clock_pin_select <= 1'b0;
      filt_prev <= '1;
      filtered_value <= '1;
      edge_flag <= '0;
    end else begin
      if (wr_take && is_debug)
        debug_clock_pin_select <= pwdata[0];
      filt_prev <= filt_out;
      filtered_value <= filt_out;
      edge_flag <= port_edge_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads
  wire [NB-1:0] pin_value_view = periph_in;
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (filt_port) begin
      unique case (sel_reg)
        gpd_pkg::REG_EDGE_POLARITY: rd_byte = port_edge_polarity[sel_port[0]];
        gpd_pkg::REG_EDGE_FLAG: rd_byte = port_edge_flag[sel_port[0]];
        gpd_pkg::REG_DEBOUNCE_CONFIG:
          rd_byte = port_debounce_config[sel_port[0]];
        default: rd_byte = 8'h00;
      endcase
    end
    unique case (sel_reg)
      gpd_pkg::REG_PIN_VALUE:
        rd_byte = pin_value_view[sel_port*8 +: 8];
      gpd_pkg::REG_OUTPUT_VALUE: rd_byte = port_output_value[sel_port];
      gpd_pkg::REG_DRIVE_ENABLE: rd_byte = port_drive_enable[sel_port];
      gpd_pkg::REG_SENSE_ENABLE: rd_byte = port_sense_enable[sel_port];
      gpd_pkg::REG_PULLUP_ENABLE: rd_byte = port_pullup_enable[sel_port];
      gpd_pkg::REG_LEVEL_SELECT:
        rd_byte = port_input_level_select[sel_port];
      gpd_pkg::REG_FUNCTION_SELECT: rd_byte = port_function_select[sel_port];
      default: rd_byte = rd_byte;
    endcase
    if (is_debug)
      rd_byte = {7'h00, debug_clock_pin_select};
  end

  // answer in the first access cycle; unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite && mapped) ? {24'h000000, rd_byte} :
        32'h0000_0000;
    end
  end
endmodule : gpd_port

/* logic/gpd_pkg.sv */
// package: register map, reset values and filter timing of the gpio port
//
// Contract
// - input mode undriven, pin level read back
// - input enable 0 reads value 0
// - output and input enabled read driven level
// - both enables 0: high impedance, read 0
// - output enabled drives stored data bit
// - data writes stored in input mode
// - peripheral function sets pin direction itself
// - per-bit pull-up, never while driving
// - pull-up still applies under peripheral function
// - reset: input, pull-up, schmitt on
// - selectable ports choose schmitt or cmos
// - two nibble filters on first two ports
// - check time 16384 down to 256 cycles
// - pass change after one check time
// - debug clock pin is output only
// - function select resets to gpio
// - filtered edge sets flag, polarity selectable
package gpd_pkg;
  localparam int NPORT = 4;
  localparam int NFILT_PORT = 2;
  localparam int PORT_W = 8;
  // register index inside one port window; byte address is four times it
  localparam logic [3:0] REG_PIN_VALUE = 4'h0;
  localparam logic [3:0] REG_OUTPUT_VALUE = 4'h1;
  localparam logic [3:0] REG_DRIVE_ENABLE = 4'h2;
  localparam logic [3:0] REG_PULLUP_ENABLE = 4'h3;
  localparam logic [3:0] REG_LEVEL_SELECT = 4'h4;
  // indices 5 and 9 belong to logic outside this block and read 0
  localparam logic [3:0] REG_EDGE_POLARITY = 4'h6;
  localparam logic [3:0] REG_EDGE_FLAG = 4'h7;
  localparam logic [3:0] REG_DEBOUNCE_CONFIG = 4'h8;
  localparam logic [3:0] REG_SENSE_ENABLE = 4'hA;
  localparam logic [3:0] REG_FUNCTION_SELECT = 4'hB;
  localparam logic [3:0] REG_LAST = 4'hB;
  // port windows are 0x40 apart; debug pin select alone at 0x100
  localparam logic [11:0] ADDR_DEBUG_SELECT = 12'h100;
  localparam int PORT_SHIFT = 6;
  // reset values
  localparam logic [7:0] RST_OUTPUT_VALUE = 8'h00;
  localparam logic [7:0] RST_DRIVE_ENABLE = 8'h00;
  localparam logic [7:0] RST_SENSE_ENABLE = 8'hFF;
  localparam logic [7:0] RST_PULLUP_ENABLE = 8'hFF;
  localparam logic [7:0] RST_LEVEL_SELECT = 8'hFF;
  localparam logic [7:0] RST_EDGE_POLARITY = 8'h00;
  localparam logic [7:0] RST_DEBOUNCE_CONFIG = 8'h00;
  localparam logic [7:0] RST_FUNCTION_SELECT = 8'h00;
  // debounce field positions and timing
  localparam int LOW_CHECK_LSB = 0;
  localparam int HIGH_CHECK_LSB = 4;
  localparam int CHECK_W = 3;
  localparam logic [2:0] CHECK_OFF = 3'h0;
  localparam int CHECK_BASE_CYCLES = 256;
  localparam int CHECK_STEPS = 7;
  // debug clock pin position
  localparam int DEBUG_PORT = 3;
  localparam int DEBUG_BIT = 3;
endpackage : gpd_pkg

/* logic/gpd_filter.sv */
// nibble chattering filter with selectable check time
`timescale 1ns/1ns
module gpd_filter #(
  parameter int BASE = gpd_pkg::CHECK_BASE_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic [2:0] check_code,
  // data
  input wire logic [3:0] din,
  output logic [3:0] dout
);
  localparam int CW = $clog2(BASE << gpd_pkg::CHECK_STEPS) + 1;

  logic [3:0] last;
  logic [CW-1:0] stable_cnt;
  wire [CW-1:0] limit = CW'(BASE) << (check_code - 3'h1);
  wire filter_off = (check_code == gpd_pkg::CHECK_OFF);
  wire changed = (din != last);
  wire reached = (stable_cnt >= limit);

  // a change must hold limit cycles before it passes; any shorter
  // pulse restarts the count and is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // start at the pulled-up idle level so no false edge follows reset
      last <= 4'hF;
      stable_cnt <= '0;
      dout <= 4'hF;
    end else begin
      last <= din;
      if (filter_off) begin
        stable_cnt <= '0;
        dout <= din;
      end else if (changed) begin
        stable_cnt <= CW'(1);
      end else if (!reached) begin
        stable_cnt <= stable_cnt + CW'(1);
      end else begin
        dout <= last;
      end
    end
  end
endmodule : gpd_filter

/* tb/gpd_pad_model.sv */
// board side of the port pins: pads, pull-ups and outside drivers
`timescale 1ns/1ns
module gpd_pad_model (
  // clock
  input wire logic pclk,
  // design side
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] pin_pullup_en,
  // board side
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_drv,
  output logic [31:0] pin_in
);
  logic [31:0] float_q = 32'h0;
  // a bare pin wanders so a stale level never passes for a read
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drv & ext_val)
    | (pin_oe_n & ~ext_drv & (pin_pullup_en | float_q));
endmodule : gpd_pad_model

/* tb/gpd_port_chk.sv */
// assertion checker for the gpio port block
`timescale 1ns/1ns
module gpd_port_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] pin_pullup_en,
  input wire logic [31:0] pin_schmitt_en,
  input wire logic [31:0] periph_in
);
  localparam int DBG = gpd_pkg::DEBUG_PORT * 8 + gpd_pkg::DEBUG_BIT;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  rdata_byte_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  pullup_drive_a: assert property ((pin_pullup_en & ~pin_oe_n) == 32'h0)
    else $error("pull-up on a driven pin");
  debug_out_a: assert property ($past(presetn) |->
    !pin_oe_n[DBG] && !pin_schmitt_en[DBG] && !periph_in[DBG])
    else $error("debug pin not output only");
  fixed_level_a: assert property (
    {pin_schmitt_en[31:28], pin_schmitt_en[26:16]} == 15'h7FFF)
    else $error("fixed port left schmitt level");
  reset_dflt_a: assert property (!$past(presetn) |->
    pin_oe_n == 32'hFFFFFFFF && pin_pullup_en == 32'hFFFFFFFF)
    else $error("pins not input with pull-up after reset");
endmodule : gpd_port_chk
bind gpd_port gpd_port_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
  .pin_schmitt_en(pin_schmitt_en), .periph_in(periph_in));

/* tb/tb_top.sv */
// self-checking bench for the gpio port block
`timescale 1ns/1ns
module tb_top;
  localparam int BASE = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, pin_in, pin_out, pin_oe_n, pin_pu, pin_sm, per_in;
  logic pready, pslverr, ev, debug_clock_pin = 1'b0;
  logic [31:0] per_out = 32'h0, per_oe = 32'h0, per_ie = 32'h0;
  logic [31:0] ext_val = 32'h0, ext_drv = 32'h0, rv;
  logic [15:0] fval, eflag;
  logic [31:0] seed = 32'h3B4C4DE2;
  logic [7:0] o, d, s, u, x;
  int failures = 0, total_checks = 0, p, lim, n;
  gpd_port #(.CHECK_BASE(BASE)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pu), .pin_schmitt_en(pin_sm), .periph_out(per_out),
    .periph_oe(per_oe), .periph_ie(per_ie), .periph_in(per_in),
    .debug_clock_src(debug_clock_pin), .filtered_value(fval), .edge_flag(eflag));
  gpd_pad_model u_pads (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pu), .ext_val(ext_val), .ext_drv(ext_drv),
    .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [11:0] ra(input int pt, input logic [3:0] i);
    return {pt[5:0], i, 2'b00};
  endfunction : ra
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] sn, e);
    total_checks++;
    if (sn !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, e, sn);
    end
  endtask : chk
  // one idle cycle after each transfer keeps psel from toggling in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] dt);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dt};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failures++;
      tally_and_finish();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] dt);
    apb(1'b1, a, dt);
  endtask : wr
  task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rv, {24'h0, e});
  endtask : rc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("oe_n reset", pin_oe_n, 32'hF7FFFFFF);
    chk("pullup reset", pin_pu, 32'hF7FFFFFF);
    for (int i = 0; i < 12; i++) begin
      rc("reset reg", ra(0, 4'(i)),
        (i == 0 || i == 3 || i == 4 || i == 10) ? 8'hFF : 8'h00);
    end
    wr(ra(0, 4'h0), 8'h00);
    rc("pin value ro", ra(0, 4'h0), 8'hFF);
    apb(1'b0, ra(0, 4'hC), 8'h00);
    chk("unmapped err", ev, 1);
    ext_drv <= 32'hFFFFFFFF;
    for (int k = 0; k < 24; k++) begin
      p = k % 3;
      o = rnd();
      d = rnd();
      s = rnd();
      u = rnd();
      x = rnd();
      ext_val[p*8 +: 8] <= x;
      wr(ra(p, 4'h1), o);
      wr(ra(p, 4'hA), s);
      wr(ra(p, 4'h3), u);
      wr(ra(p, 4'h2), d);
      repeat (4) @(posedge pclk);
      rc("pin value", ra(p, 4'h0), s & (d & o | ~d & x));
      rc("out reg", ra(p, 4'h1), o);
      chk("drive", pin_out[p*8 +: 8] & d, o & d);
      chk("oe_n", pin_oe_n[p*8 +: 8], {24'h0, ~d});
      chk("pullup", pin_pu[p*8 +: 8], u & ~d);
      chk("periph in", per_in[p*8 +: 8], s & (d & o | ~d & x));
    end
    d = rnd();
    o = rnd();
    per_oe[15:8] <= d;
    per_out[15:8] <= o;
    per_ie[15:8] <= rnd();
    wr(ra(1, 4'h2), 8'hFF);
    wr(ra(1, 4'h3), 8'hFF);
    wr(ra(1, 4'hB), 8'hFF);
    repeat (3) @(posedge pclk);
    chk("periph oe", pin_oe_n[15:8], {24'h0, ~d});
    chk("periph out", pin_out[15:8] & d, o & d);
    chk("periph pu", pin_pu[15:8], {24'h0, ~d});
    wr(ra(1, 4'hB), 8'h00);
    wr(ra(0, 4'h4), 8'h5A);
    wr(ra(2, 4'h4), 8'h00);
    repeat (2) @(posedge pclk);
    chk("level", pin_sm[7:0], 32'h5A);
    rc("fixed level", ra(2, 4'h4), 8'hFF);
    wr(ra(0, 4'h2), 8'h00);
    wr(ra(0, 4'hA), 8'hFF);
    ext_val[7:0] <= 8'h00;
    for (int c = 1; c < 8; c++) begin
      lim = BASE << (c - 1);
      wr(ra(0, 4'h6), 8'(c & 1));
      wr(ra(0, 4'h8), 8'(c));
      // settle before clearing, as software must while retuning
      repeat (2 * lim + 8) @(posedge pclk);
      wr(ra(0, 4'h7), 8'hFF);
      ext_val[0] <= 1'b1;
      ext_val[4] <= 1'b1;
      repeat (lim / 2) @(posedge pclk);
      ext_val[0] <= 1'b0;
      ext_val[4] <= 1'b0;
      repeat (2 * lim + 8) @(posedge pclk);
      rc("short pulse", ra(0, 4'h7), 8'h10);
      wr(ra(0, 4'h7), 8'hFF);
      ext_val[0] <= 1'b1;
      n = 0;
      while (fval[0] !== 1'b1 && n < 2 * lim + 8) begin
        @(posedge pclk);
        n++;
      end
      chk("pass time", n >= lim && n < 2 * lim + 8, 1);
      if (n >= 2 * lim + 8) tally_and_finish();
      repeat (4) @(posedge pclk);
      rc("rise flag", ra(0, 4'h7), 8'(~c & 1));
      wr(ra(0, 4'h7), 8'hFF);
      ext_val[0] <= 1'b0;
      repeat (2 * lim + 8) @(posedge pclk);
      chk("fall flag", eflag[0], c & 1);
    end
    // debug clock pin: source level first, then the gpio data bit
    debug_clock_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("debug src", pin_out[27], 1);
    wr(12'h100, 8'h01);
    repeat (2) @(posedge pclk);
    chk("debug gpio", pin_out[27], 0);
    rc("debug select", 12'h100, 8'h01);
    // before sleep: filters off, pull-up back on the unused port
    wr(ra(0, 4'h8), 8'h00);
    rc("filter off", ra(0, 4'h8), 8'h00);
    wr(ra(0, 4'h3), 8'hFF);
    repeat (2) @(posedge pclk);
    chk("unused pullup", pin_pu[7:0], 8'hFF);
    tally_and_finish();
  end
endmodule : tb_top
